// *** shared/mdd_pkg.sv ***
/*
  Constants and carrier types for the matrix driver addressing decoder.
  Assumes a 250 MHz reference clock and a host serial link on its own clock.
*/
`default_nettype none
package mdd_pkg;
    // reference clock and the one-second base of the plane switcher
    localparam int REF_PERIOD_NS = 4;
    localparam int SECOND_NS = 1000000000;
    localparam int SEC_CYCLES = SECOND_NS / REF_PERIOD_NS;

    // accepted transmission lengths and bit counter ceiling
    localparam logic [4:0] BITS_DATA = 5'h08;
    localparam logic [4:0] BITS_CMD = 5'h10;
    localparam logic [4:0] BITS_DIRECT = 5'h18;
    localparam logic [4:0] BITS_MAX = 5'h1F;
    localparam logic [3:0] READ_BITS = 4'h8;

    // configuration register offsets
    localparam logic [3:0] REG_PANEL_CFG = 4'h0;
    localparam logic [3:0] REG_DISP_LOW = 4'h9;
    localparam logic [3:0] REG_DISP_HIGH = 4'hA;
    localparam logic [3:0] REG_PLANE_CTR = 4'hB;
    localparam logic [3:0] REG_DRV_PTR = 4'hC;

    // field positions
    localparam int CFG_COLOUR_BIT = 0;
    localparam int CFG_DEPTH_BIT = 1;
    localparam int CFG_RED_GEO_BIT = 2;
    localparam int CFG_GREEN_GEO_BIT = 3;
    localparam int PC_AUTO_BIT = 6;
    localparam int PC_SLOW_BIT = 7;
    localparam int C16_RW_BIT = 15;
    localparam int C16_INC_BIT = 14;
    localparam int C16_GLOBAL_BIT = 13;
    localparam int C16_RESV_BIT = 12;
    localparam int C24_RW_BIT = 23;

    // values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [13:0] RST_PTR = 14'h0000;

    // super frame length and modulation patterns, bit i is multiplex cycle i
    localparam logic [3:0] SUPER_LAST = 4'hB;
    localparam logic [11:0] PAT_TWO_THIRD = 12'hB6D;
    localparam logic [11:0] PAT_ONE_THIRD = 12'h492;
    localparam logic [11:0] PAT_HALF = 12'h555;
    localparam logic [11:0] PAT_QUARTER = 12'h222;

    // one received transmission
    typedef struct packed {
        logic [4:0] count;
        logic [23:0] word;
    } mdd_frame_s;

    // one display memory write
    typedef struct packed {
        logic we;
        logic [5:0] addr;
        logic [7:0] data;
    } mdd_wr_s;
endpackage : mdd_pkg
`default_nettype wire

// *** src/mdd_plane_ram.sv ***
/*
  64-byte display plane memory: one write port, two registered read ports.
  Assumes the reference clock and its clock enable from the decoder.
*/
`timescale 1ns/1ps
`default_nettype none
module mdd_plane_ram (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    // write port
    input wire mdd_pkg::mdd_wr_s wr,
    // host read port
    input wire logic [5:0] hostAddr,
    output logic [7:0] hostData,
    // refresh read port
    input wire logic [5:0] refAddr,
    output logic [7:0] refData
);
    import mdd_pkg::*;

    logic [7:0] mem [64];

    // byte write
    always_ff @(posedge ref_clk)
    begin
        if (ce && wr.we)
        begin
            mem[wr.addr] <= wr.data;
        end
    end

    // registered reads
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hostData <= RST_BYTE;
            refData <= RST_BYTE;
        end
        else if (ce)
        begin
            hostData <= mem[hostAddr];
            refData <= mem[refAddr];
        end
    end
endmodule : mdd_plane_ram
`default_nettype wire

// *** src/mdd_decoder.sv ***
/*
  Host serial decoder and display addressing of one cascaded matrix driver.
  Assumes the chain logic supplies driverNum and the refresh engine asks
  for plane bytes and pulses frameStep once per multiplex frame.
*/
// Notes on behaviour
// - arithmetic codes: full, 2/3, 1/3, off patterns
// - geometric codes: full, 1/2, 1/4, off patterns
// - 64 bytes: four 16-byte or two 32-byte planes
// - plane layout follows colour and depth mode
// - one plane refreshed, chosen directly or automatically
// - auto rate 63 per second to one per 63s
// - 14-bit space shared by 256 drivers
// - every driver decodes every transmission
// - 8-bit data goes to display pointer location
// - display pointer increments after each data byte
// - 16-bit fields: rw, increment, global, zero, addr, data
// - global writes all drivers, specific one driver
// - 16-bit reads answered by pointed driver only
// - pointer-routed command with flag bumps driver pointer
// - mono 1-bit: plane 0-3, 12-bit byte address
// - bicolour 1-bit: 2048 red then 2048 green
// - bicolour 2-bit: plane 0-1, 13-bit address
// - mono 2-bit: plane 0-1, four pixels a byte
// - patterns repeat over twelve multiplex frames
// - lengths other than 8, 16, 24 discarded
// - set top bit reads; answer 8 bits, MSB first
`timescale 1ns/1ps
`default_nettype none
module mdd_decoder #(
    parameter int SEC_CYCLES = mdd_pkg::SEC_CYCLES
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    // host serial link
    input wire logic serClk,
    input wire logic chipSelB,
    input wire logic dataIn,
    output logic dataOut,
    output logic dataOutEn,
    // chain-assigned identity
    input wire logic [7:0] driverNum,
    // refresh side
    input wire logic [4:0] refreshByte,
    input wire logic frameStep,
    output logic [7:0] pixelEnable,
    output logic [1:0] refreshPlane,
    output logic [3:0] superPos
);
    import mdd_pkg::*;

    logic [23:0] shiftReg;
    logic [4:0] bitCnt;
    logic clrHold;
    logic linkClr;
    logic csSync1, csSync2, csPrev;
    logic frameEnd;
    mdd_frame_s frame;
    logic [23:0] w;
    logic is8, is16, is24;
    logic selected, pi, col, autoOn, slowMode;
    logic cmdWrite, cmdRead, memRead, indirected;
    logic [3:0] regAddr;
    logic [7:0] regData, regValue, ptrNew;
    logic [13:0] ptrMap, dirMap;
    mdd_wr_s wr;
    logic [13:0] dispPtr;
    logic [7:0] drvPtr;
    logic [7:0] regFile [16];
    logic rdPend, rdFromMem, rdArm, rdClr;
    logic [7:0] rdRegVal, readByte, hostData, refData;
    logic [3:0] rdRise, rdFall;
    logic [27:0] acc;
    logic [28:0] accSum;
    logic [5:0] secCnt, rate, step;
    logic tick, change;
    logic [5:0] refAddr;
    logic refColD, geoSel;
    logic [3:0] pixMod;

    // owner driver and local byte of a 14-bit display address
    function automatic logic [13:0] mapAddr(input logic depth, input logic bicol, input logic [13:0] a);
        logic [13:0] r;
        r = '0;
        unique case ({depth, bicol})
            2'b00: r = {a[11:4], a[13:12], a[3:0]};
            2'b01: r = {a[10:3], a[13:12], a[11], a[2:0]};
            2'b10: r = {a[12:5], a[13], a[4:0]};
            2'b11: r = {a[11:4], a[13], a[3], a[12], a[2:0]};
        endcase
        return r;
    endfunction : mapAddr

    // enable of one two-bit pixel in the current multiplex frame
    function automatic logic pixOn(input logic [1:0] code, input logic geo, input logic [3:0] pos);
        logic on;
        on = 1'b0;
        unique case (code)
            2'b11: on = 1'b1;
            2'b10: on = geo ? PAT_HALF[pos] : PAT_TWO_THIRD[pos];
            2'b01: on = geo ? PAT_QUARTER[pos] : PAT_ONE_THIRD[pos];
            2'b00: on = 1'b0;
        endcase
        return on;
    endfunction : pixOn

    // link side: shift bits in while selected, cleared once the frame is taken
    assign linkClr = ~rst_b | clrHold;
    always_ff @(posedge serClk or posedge linkClr)
    begin
        if (linkClr)
        begin
            shiftReg <= '0;
            bitCnt <= '0;
        end
        else if (!chipSelB)
        begin
            shiftReg <= {shiftReg[22:0], dataIn};
            if (bitCnt != BITS_MAX)
            begin
                bitCnt <= bitCnt + 5'h01;
            end
        end
    end

    // chip select crossing; link words are quiet while it is high
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            csSync1 <= 1'b1;
            csSync2 <= 1'b1;
            csPrev <= 1'b1;
        end
        else if (ce)
        begin
            csSync1 <= chipSelB;
            csSync2 <= csSync1;
            csPrev <= csSync2;
        end
    end

    // frame boundary and clear handshake back to the link side
    assign frameEnd = ce & csSync2 & ~csPrev;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            clrHold <= 1'b0;
        end
        else if (ce)
        begin
            if (frameEnd)
            begin
                clrHold <= 1'b1;
            end
            else if (!csSync2)
            begin
                clrHold <= 1'b0;
            end
        end
    end

    // decode of the finished transmission, done by every driver
    assign frame = '{count: bitCnt, word: shiftReg};
    assign w = frame.word;
    assign is8 = frame.count == BITS_DATA;
    assign is16 = frame.count == BITS_CMD;
    assign is24 = frame.count == BITS_DIRECT;
    assign regAddr = w[11:8];
    assign regData = w[7:0];
    assign selected = drvPtr == driverNum;
    assign pi = regFile[REG_PANEL_CFG][CFG_DEPTH_BIT];
    assign col = regFile[REG_PANEL_CFG][CFG_COLOUR_BIT];
    always_comb
    begin
        cmdWrite = frameEnd & is16 & ~w[C16_RW_BIT] & ~w[C16_RESV_BIT] & (w[C16_GLOBAL_BIT] | selected);
        cmdRead = frameEnd & is16 & w[C16_RW_BIT] & ~w[C16_RESV_BIT] & selected;
        indirected = frameEnd & is16 & ~w[C16_RESV_BIT] & (w[C16_RW_BIT] | ~w[C16_GLOBAL_BIT]);
        ptrMap = mapAddr(pi, col, dispPtr);
        dirMap = mapAddr(pi, col, w[21:8]);
        wr.we = frameEnd & ((is8 & (ptrMap[13:6] == driverNum))
              | (is24 & ~w[C24_RW_BIT] & (dirMap[13:6] == driverNum)));
        wr.addr = is8 ? ptrMap[5:0] : dirMap[5:0];
        wr.data = regData;
        memRead = frameEnd & is24 & w[C24_RW_BIT] & (dirMap[13:6] == driverNum);
    end

    // configuration register file, one process per entry
    for (genvar i = 0; i < 16; i++)
    begin : g_reg
        always_ff @(posedge ref_clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                regFile[i] <= RST_BYTE;
            end
            else if (cmdWrite && regAddr == 4'(i))
            begin
                regFile[i] <= regData;
            end
        end
    end

    // display pointer: loaded by command, bumped by every data byte
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dispPtr <= RST_PTR;
        end
        else if (frameEnd && is8)
        begin
            dispPtr <= dispPtr + 14'h0001;
        end
        else if (cmdWrite && regAddr == REG_DISP_LOW)
        begin
            dispPtr[7:0] <= regData;
        end
        else if (cmdWrite && regAddr == REG_DISP_HIGH)
        begin
            dispPtr[13:8] <= regData[5:0];
        end
    end

    // driver pointer: written by command, bumped after routed commands with the increment flag
    assign ptrNew = (cmdWrite && regAddr == REG_DRV_PTR) ? regData : drvPtr;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            drvPtr <= RST_BYTE;
        end
        else if (frameEnd && is16)
        begin
            drvPtr <= (indirected && w[C16_INC_BIT]) ? ptrNew + 8'h01 : ptrNew;
        end
    end

    // register read value
    always_comb
    begin
        unique case (regAddr)
            REG_DISP_LOW: regValue = dispPtr[7:0];
            REG_DISP_HIGH: regValue = {2'b00, dispPtr[13:8]};
            REG_DRV_PTR: regValue = drvPtr;
            default: regValue = regFile[regAddr];
        endcase
    end

    // read answer: capture the byte, then arm the readback
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdPend <= 1'b0;
            rdFromMem <= 1'b0;
            rdRegVal <= RST_BYTE;
            readByte <= RST_BYTE;
            rdArm <= 1'b0;
        end
        else if (ce)
        begin
            rdPend <= cmdRead | memRead;
            rdFromMem <= memRead;
            rdRegVal <= regValue;
            if (rdPend)
            begin
                readByte <= rdFromMem ? hostData : rdRegVal;
                rdArm <= 1'b1;
            end
            else if (!csSync2)
            begin
                rdArm <= 1'b0;
            end
        end
    end

    // readback on the link clock: change after falling edges, MSB first
    assign rdClr = ~rdArm;
    always_ff @(posedge serClk or posedge rdClr)
    begin
        if (rdClr)
        begin
            rdRise <= '0;
        end
        else if (chipSelB && rdRise != READ_BITS)
        begin
            rdRise <= rdRise + 4'h1;
        end
    end
    always_ff @(negedge serClk or posedge rdClr)
    begin
        if (rdClr)
        begin
            rdFall <= '0;
        end
        else
        begin
            rdFall <= rdRise;
        end
    end
    assign dataOut = readByte[~rdFall[2:0]];
    assign dataOutEn = rdArm & chipSelB & (rdFall != READ_BITS);

    // plane switch timing: step accumulator over one second
    assign autoOn = regFile[REG_PLANE_CTR][PC_AUTO_BIT];
    assign slowMode = regFile[REG_PLANE_CTR][PC_SLOW_BIT];
    assign rate = regFile[REG_PLANE_CTR][5:0];
    assign step = slowMode ? 6'h01 : rate;
    assign accSum = {1'b0, acc} + {23'h000000, step};
    assign tick = accSum >= 29'(SEC_CYCLES);
    assign change = tick & (~slowMode | (secCnt == rate - 6'h01));
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            acc <= '0;
            secCnt <= '0;
        end
        else if (ce)
        begin
            if (!autoOn || rate == 6'h00)
            begin
                acc <= '0;
                secCnt <= '0;
            end
            else
            begin
                acc <= tick ? 28'(accSum - 29'(SEC_CYCLES)) : accSum[27:0];
                if (tick && slowMode)
                begin
                    secCnt <= change ? 6'h00 : secCnt + 6'h01;
                end
            end
        end
    end

    // refreshed plane, direct or automatic
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            refreshPlane <= 2'b00;
        end
        else if (ce)
        begin
            if (!autoOn)
            begin
                refreshPlane <= pi ? {1'b0, regFile[REG_PLANE_CTR][0]} : regFile[REG_PLANE_CTR][1:0];
            end
            else if (change)
            begin
                refreshPlane <= pi ? {1'b0, ~refreshPlane[0]} : refreshPlane + 2'b01;
            end
        end
    end

    // super frame position
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            superPos <= 4'h0;
        end
        else if (ce && frameStep)
        begin
            superPos <= (superPos == SUPER_LAST) ? 4'h0 : superPos + 4'h1;
        end
    end

    // plane memory and its refresh address
    assign refAddr = pi ? {refreshPlane[0], refreshByte} : {refreshPlane, refreshByte[3:0]};
    mdd_plane_ram u_ram (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ce(ce),
        .wr(wr),
        .hostAddr(dirMap[5:0]),
        .hostData(hostData),
        .refAddr(refAddr),
        .refData(refData)
    );

    // pixel enables from the fetched byte
    assign geoSel = (col && refColD) ? regFile[REG_PANEL_CFG][CFG_GREEN_GEO_BIT]
                                     : regFile[REG_PANEL_CFG][CFG_RED_GEO_BIT];
    for (genvar p = 0; p < 4; p++)
    begin : g_pix
        assign pixMod[p] = pixOn(refData[2*p+1:2*p], geoSel, superPos);
    end
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            refColD <= 1'b0;
            pixelEnable <= RST_BYTE;
        end
        else if (ce)
        begin
            refColD <= refreshByte[3];
            pixelEnable <= pi ? {4'h0, pixMod} : refData;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence s_read16;
        frameEnd && is16 && w[C16_RW_BIT] && !w[C16_RESV_BIT] && selected;
    endsequence
    sequence s_answer;
        ce && rdPend ##1 rdArm;
    endsequence

    disp_ptr_inc_a: assert property (frameEnd && is8 |=> dispPtr == $past(dispPtr) + 14'h0001)
        else $error("display pointer did not advance");
    bad_len_a: assert property (frameEnd && !(is8 || is16 || is24) |-> !wr.we ##1 !rdPend)
        else $error("odd length transmission acted on");
    global_wr_a: assert property (frameEnd && is16 && !w[15] && w[13] && !w[12] && regAddr == REG_PANEL_CFG
        |=> regFile[REG_PANEL_CFG] == $past(regData))
        else $error("global write not stored");
    specific_skip_a: assert property (frameEnd && is16 && !w[15] && !w[13] && !selected
        |=> $stable(dispPtr) && $stable(regFile[REG_PLANE_CTR]))
        else $error("unselected driver took a specific write");
    drv_inc_a: assert property (indirected && w[C16_INC_BIT] && !(cmdWrite && regAddr == REG_DRV_PTR)
        |=> drvPtr == $past(drvPtr) + 8'h01)
        else $error("driver pointer not incremented");
    read_only_sel_a: assert property (frameEnd && is16 && !selected && !memRead |=> !rdPend)
        else $error("unselected driver answered a read");
    read_answer_a: assert property (s_read16 |=> s_answer)
        else $error("read not answered");
    super_wrap_a: assert property (ce && frameStep && superPos == SUPER_LAST |=> superPos == 4'h0)
        else $error("super frame did not wrap at twelve");
    full_code_a: assert property (ce && pi && $past(ce) && refData[1:0] == 2'b11 |=> pixelEnable[0])
        else $error("full code pixel disabled");
    geo_half_a: assert property (ce && pi && geoSel && refData[1:0] == 2'b10
        |=> pixelEnable[0] == ~$past(superPos[0]))
        else $error("half pattern wrong");
    plane_range_a: assert property (pi && $past(pi) |-> !refreshPlane[1] || $past(!pi, 2))
        else $error("plane out of range in two-bit mode");
endmodule : mdd_decoder
`default_nettype wire

// *** sim/mdd_host_model.sv ***
/*
  Host side of the four-wire serial link: frames out, readback bytes in.
  Assumes the bench calls send and fetch; the link clock idles low between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module mdd_host_model (
    // serial link
    output logic serClk,
    output logic chipSelB,
    output logic dataIn,
    input wire logic dataOut,
    input wire logic dataOutEn
);
    // idle link
    initial
    begin
        serClk = 1'b0;
        chipSelB = 1'b1;
        dataIn = 1'b0;
    end

    // n bits msb first, data set while clock low, select rises with clock high
    task automatic send(input logic [23:0] word, input int n);
        #0.7 chipSelB = 1'b0;
        #24;
        for (int i = n - 1; i >= 0; i--)
        begin
            serClk = 1'b0;
            dataIn = word[i];
            #16;
            serClk = 1'b1;
            #16;
        end
        chipSelB = 1'b1;
        dataIn = ~dataIn; // released line must not keep its last value
        #16;
        serClk = 1'b0;
        #48;
    endtask : send

    // eight readback bits, each taken at a rising link edge
    task automatic fetch(output logic [7:0] b, output logic seen);
        seen = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            #16;
            serClk = 1'b1;
            b[i] = dataOut;
            seen = seen | dataOutEn;
            #16;
            serClk = 1'b0;
        end
        #48;
    endtask : fetch
endmodule : mdd_host_model
`default_nettype wire

// *** sim/tb.sv ***
/*
  Self-checking bench for the matrix driver decoder.
  Assumes the host model drives the link; refresh inputs come from here.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mdd_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic frameStep = 1'b0;
    logic [4:0] refreshByte = 5'h00;
    logic [7:0] pixelEnable;
    logic [1:0] refreshPlane;
    logic [3:0] superPos;
    logic [7:0] rb;
    logic en;
    wire logic serClk, chipSelB, dataIn, dataOut, dataOutEn;
    int fail_count = 0;
    int checks_done = 0;

    // reference clock and watchdog
    always #2 ref_clk = ~ref_clk;
    initial
    begin
        #400000;
        fail_count++;
        summarize();
    end

    // unit under test and host
    mdd_decoder #(.SEC_CYCLES(240)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .ce(1'b1), .serClk(serClk),
        .chipSelB(chipSelB), .dataIn(dataIn), .dataOut(dataOut), .dataOutEn(dataOutEn), .driverNum(8'h00),
        .refreshByte(refreshByte), .frameStep(frameStep), .pixelEnable(pixelEnable),
        .refreshPlane(refreshPlane), .superPos(superPos));
    mdd_host_model host (.serClk(serClk), .chipSelB(chipSelB), .dataIn(dataIn), .dataOut(dataOut),
        .dataOutEn(dataOutEn));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    task automatic wr16(input logic [3:0] a, input logic [7:0] d, input logic g, input logic inc);
        host.send({8'h00, 1'b0, inc, g, 1'b0, a, d}, 16);
    endtask : wr16

    task automatic rd16(input logic [3:0] a);
        host.send({8'h00, 4'h8, a, 8'h00}, 16);
        host.fetch(rb, en);
    endtask : rd16

    task automatic pix(input logic [4:0] k, input logic [7:0] exp);
        @(posedge ref_clk) #1 refreshByte = k;
        repeat (3) @(posedge ref_clk);
        #1 check("pixel byte", pixelEnable, exp);
    endtask : pix

    task automatic step();
        @(posedge ref_clk) #1 frameStep = 1'b1;
        @(posedge ref_clk) #1 frameStep = 1'b0;
    endtask : step

    task automatic t_reset();
        check("pixels", pixelEnable, 8'h00);
        check("plane", {6'h00, refreshPlane}, 8'h00);
        check("position", {4'h0, superPos}, 8'h00);
        check("out enable", {7'h00, dataOutEn}, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_regs();
        wr16(REG_DISP_LOW, 8'h34, 1'b1, 1'b0);
        wr16(REG_DISP_HIGH, 8'hFF, 1'b1, 1'b0);
        rd16(REG_DISP_LOW);
        check("pointer low", rb, 8'h34);
        check("answered", {7'h00, en}, 8'h01);
        rd16(REG_DISP_HIGH);
        check("pointer high", rb, 8'h3F);
        $display("test regs done");
    endtask : t_regs

    task automatic t_data();
        wr16(REG_DISP_LOW, 8'h00, 1'b1, 1'b0);
        wr16(REG_DISP_HIGH, 8'h00, 1'b1, 1'b0);
        host.send(24'h0000A5, 8);
        host.send(24'h00003C, 8);
        host.send(24'h0001FF, 9);
        host.send(24'h000FFF, 12);
        rd16(REG_DISP_LOW);
        check("pointer after data", rb, 8'h02);
        pix(5'h00, 8'hA5);
        pix(5'h01, 8'h3C);
        pix(5'h02, 8'h00);
        wr16(REG_DISP_LOW, 8'h10, 1'b1, 1'b0);
        host.send(24'h0000EE, 8);
        rd16(REG_DISP_LOW);
        check("foreign pointer", rb, 8'h11);
        pix(5'h00, 8'hA5);
        $display("test data done");
    endtask : t_data

    task automatic t_direct();
        host.send({2'b00, 2'b01, 12'h002, 8'h5A}, 24);
        wr16(REG_PLANE_CTR, 8'h01, 1'b1, 1'b0);
        repeat (4) @(posedge ref_clk);
        check("manual plane", {6'h00, refreshPlane}, 8'h01);
        pix(5'h02, 8'h5A);
        host.send({2'b10, 2'b01, 12'h002, 8'h00}, 24);
        host.fetch(rb, en);
        check("direct read", rb, 8'h5A);
        wr16(REG_PLANE_CTR, 8'h00, 1'b1, 1'b0);
        $display("test direct done");
    endtask : t_direct

    task automatic t_drvptr();
        wr16(REG_DISP_LOW, 8'h77, 1'b0, 1'b1);
        rd16(REG_DISP_LOW);
        check("other driver silent", {7'h00, en}, 8'h00);
        wr16(REG_DRV_PTR, 8'h00, 1'b1, 1'b0);
        rd16(REG_DISP_LOW);
        check("specific write", rb, 8'h77);
        $display("test driver pointer done");
    endtask : t_drvptr

    task automatic t_mod();
        logic [11:0] pa;
        logic [11:0] pb;
        int pos;
        pos = 0;
        for (int g = 0; g < 2; g++)
        begin
            wr16(REG_PANEL_CFG, g ? 8'h0E : 8'h02, 1'b1, 1'b0);
            host.send({2'b00, 14'h0000, 8'h1B}, 24);
            pa = g ? PAT_HALF : PAT_TWO_THIRD;
            pb = g ? PAT_QUARTER : PAT_ONE_THIRD;
            for (int i = 0; i < 13; i++)
            begin
                check("super position", {4'h0, superPos}, 8'(pos));
                pix(5'h00, {5'h00, pb[pos], pa[pos], 1'b1});
                step();
                pos = (pos == 11) ? 0 : pos + 1;
            end
        end
        $display("test modulation done");
    endtask : t_mod

    task automatic t_auto();
        int n;
        logic [1:0] p;
        n = 0;
        wr16(REG_PLANE_CTR, 8'h42, 1'b1, 1'b0);
        for (int s = 0; s < 2; s++)
        begin
            p = refreshPlane;
            n = 0;
            while (refreshPlane === p && n < 400)
            begin
                @(posedge ref_clk);
                n++;
            end
            if (n >= 400)
            begin
                fail_count++;
                summarize();
            end
        end
        check("auto interval", 8'(n >= 115 && n <= 125), 8'h01);
        $display("test auto plane done");
    endtask : t_auto

    // main sequence
    initial
    begin
        repeat (16) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge ref_clk);
        t_reset();
        t_regs();
        t_data();
        t_direct();
        t_drvptr();
        t_mod();
        t_auto();
        summarize();
    end
endmodule : tb
`default_nettype wire
